// File: logic/spm_framer.sv
//  Purpose : serialises one peak value into the side channel bit
//  Assumes : step pulses once per link sample
//  Notes   : a load while a frame is still going out is dropped
`timescale 1ns/1ps
module spm_framer (
    input  wire logic                        core_clk,
    input  wire logic                        rst,
    input  wire logic                        load,
    input  wire logic [spm_pkg::PEAK_W-1:0]  peak,
    input  wire logic                        step,
    output logic                             tx_bit,
    output logic                             busy
);
    import spm_pkg::*;

    typedef struct packed {
        logic [FRAME_W-1:0] shift;
        logic [4:0]         left;
    } spm_frm_s;

    spm_frm_s st_reg;
    spm_frm_s st_next;

    // ==================================================================
    // outputs: idle line stays low so a start bit is unambiguous
    assign busy   = (st_reg.left != 5'h00);
    assign tx_bit = busy & st_reg.shift[FRAME_W-1];

    // ==================================================================
    // shift one bit per sample, load only when idle
    always_comb begin
        st_next = st_reg;
        if (step && busy) begin
            st_next.shift = {st_reg.shift[FRAME_W-2:0], 1'b0};
            st_next.left  = st_reg.left - 5'h01;
        end else if (load && !busy) begin
            st_next.shift = spm_pack(peak);
            st_next.left  = FRAME_CNT;
        end
    end

    // state register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule

// File: logic/spm_link_if.sv
//  Purpose : output sample link between monitor and link receiver
//  Assumes : both ends share core_clk
//  Notes   : one sample per valid cycle, control bits beside it
`timescale 1ns/1ps
interface spm_link_if;
    import spm_pkg::*;

    // ==================================================================
    // link signals
    logic                link_valid;
    logic [SAMPLE_W-1:0] link_sample;
    logic [CTRL_W-1:0]   link_ctrl;

    modport dev (output link_valid, output link_sample, output link_ctrl);
    modport rx  (input  link_valid, input  link_sample, input  link_ctrl);
endinterface

// File: logic/spm_monitor.sv
//  Purpose : peak magnitude monitor with bus registers and side channel
//  Assumes : in_valid marks one decimated sample per pulse
//  Notes   : registers are 8 bits wide in the low byte of a bus word
//
// Behaviour
// - track magnitude only, sign ignored
// - peak is 13-bit unsigned
// - one 24-bit period in samples
// - control bit 1 enables peak detection
// - software writes period before enabling
// - enable loads timer, decrement per sample
// - keep larger of sample and running peak
// - seed running peak with current sample
// - at count one copy peak to holding
// - reload timer and reseed each period
// - side channel needs both link enables
// - three control bits, monitor uses one
// - control bits filled from msb downward
// - 25-bit frame, five 5-bit subframes, msb first
// - each subframe opens with start bit
// - receiver reassembles frame from control bits
// - software configures link routing registers
// - dBFS is 20log(peak / 2^13)
`timescale 1ns/1ps
module spm_monitor (
    input  wire logic                          core_clk,
    input  wire logic                          rst,
    // classic wishbone slave
    input  wire logic                          wb_cyc,
    input  wire logic                          wb_stb,
    input  wire logic                          wb_we,
    input  wire logic [spm_pkg::ADR_W-1:0]     wb_adr,
    input  wire logic [3:0]                    wb_sel,
    input  wire logic [31:0]                   wb_dat_w,
    output logic      [31:0]                   wb_dat_r,
    output logic                               wb_ack,
    // sample stream
    input  wire logic                          in_valid,
    input  wire logic [spm_pkg::SAMPLE_W-1:0]  in_sample,
    // link toward receiver
    spm_link_if.dev                            link
);
    import spm_pkg::*;

    typedef struct packed {
        logic [7:0]          ctrl;
        logic [7:0]          link_a;
        logic [7:0]          link_b;
        logic [PERIOD_W-1:0] period;
        logic [PEAK_W-1:0]   hold;
        logic [PERIOD_W-1:0] timer;
        logic [PEAK_W-1:0]   run;
        logic                seed;
        logic                en_d;
        logic                new_peak;
        logic                ack;
        logic [31:0]         rdata;
        logic                lvalid;
        logic [SAMPLE_W-1:0] lsample;
        logic [CTRL_W-1:0]   lctrl;
    } spm_mon_s;

    spm_mon_s st_reg;
    spm_mon_s st_next;

    logic [IDX_W-1:0]  idx;
    logic              wr;
    logic              rd;
    logic              pk_en;
    logic              side_en;
    logic [PEAK_W-1:0] mag;
    logic [PEAK_W-1:0] cand;
    logic              frm_bit;

    // ==================================================================
    // bus decode: answer one cycle after the strobe, then drop
    assign idx     = wb_adr[ADR_W-1:2];
    assign rd      = wb_cyc & wb_stb & ~st_reg.ack;
    assign wr      = rd & wb_we & wb_sel[0];
    assign pk_en   = st_reg.ctrl[PEAK_EN_BIT];
    assign side_en = (st_reg.link_a[1:0] == LINK_A_MASK)
                   & st_reg.link_b[LINK_B_BIT];
    assign mag     = spm_mag(in_sample);
    // seed on a new measurement, else keep the larger
    assign cand    = st_reg.seed ? mag
                   : ((mag > st_reg.run) ? mag : st_reg.run);

    assign wb_ack      = st_reg.ack;
    assign wb_dat_r    = st_reg.rdata;
    assign link.link_valid  = st_reg.lvalid;
    assign link.link_sample = st_reg.lsample;
    assign link.link_ctrl   = st_reg.lctrl;

    // ==================================================================
    // side channel serialiser
    spm_framer u_framer (
        .core_clk (core_clk),
        .rst      (rst),
        .load     (st_reg.new_peak & side_en),
        .peak     (st_reg.hold),
        .step     (in_valid),
        .tx_bit   (frm_bit),
        .busy     ()
    );

    // ==================================================================
    // next state
    always_comb begin
        st_next          = st_reg;
        st_next.ack      = rd;
        st_next.new_peak = 1'b0;
        st_next.en_d     = pk_en;

        // register writes, low byte lane only
        if (wr) begin
            unique case (idx)
                IDX_CTRL:   st_next.ctrl   = wb_dat_w[7:0];
                IDX_LINK_A: st_next.link_a = wb_dat_w[7:0];
                IDX_LINK_B: st_next.link_b = wb_dat_w[7:0];
                IDX_PER_0:  st_next.period[7:0]   = wb_dat_w[7:0];
                IDX_PER_1:  st_next.period[15:8]  = wb_dat_w[7:0];
                IDX_PER_2:  st_next.period[23:16] = wb_dat_w[7:0];
                default:    ;
            endcase
        end

        // register reads, unmapped reads as zero
        if (rd) begin
            unique case (idx)
                IDX_CTRL:   st_next.rdata = {24'h000000, st_reg.ctrl};
                IDX_LINK_A: st_next.rdata = {24'h000000, st_reg.link_a};
                IDX_LINK_B: st_next.rdata = {24'h000000, st_reg.link_b};
                IDX_PER_0:  st_next.rdata = {24'h000000, st_reg.period[7:0]};
                IDX_PER_1:  st_next.rdata = {24'h000000, st_reg.period[15:8]};
                IDX_PER_2:  st_next.rdata = {24'h000000,
                                             st_reg.period[23:16]};
                IDX_HOLD_L: st_next.rdata = {24'h000000, st_reg.hold[7:0]};
                IDX_HOLD_H: st_next.rdata = {27'h0000000,
                                             st_reg.hold[12:8]};
                default:    st_next.rdata = 32'h00000000;
            endcase
        end

        // measurement engine
        if (!pk_en) begin
            st_next.timer = '0;
            st_next.seed  = 1'b1;
        end else if (!st_reg.en_d) begin
            // period is taken as written before the enable
            st_next.timer = st_reg.period;
            st_next.seed  = 1'b1;
        end else if (in_valid) begin
            if (st_reg.timer <= 24'h000001) begin
                st_next.hold     = cand;
                st_next.new_peak = 1'b1;
                st_next.timer    = st_reg.period;
                st_next.seed     = 1'b1;
            end else begin
                st_next.run   = cand;
                st_next.seed  = 1'b0;
                st_next.timer = st_reg.timer - 24'h000001;
            end
        end

        // link output: monitor bit rides the top control position
        st_next.lvalid  = in_valid;
        st_next.lsample = in_sample;
        st_next.lctrl   = '0;
        // gated by the sample so an idle link cycle never shows a stray bit
        st_next.lctrl[MON_CTRL_POS] = side_en & frm_bit
                                    & in_valid;
    end

    // ==================================================================
    // state register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_reg        <= '0;
            st_reg.ctrl   <= RST_REG8;
            st_reg.period <= RST_PERIOD;
            st_reg.seed   <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule

// File: logic/spm_pkg.sv
//  Purpose : shared constants, types and helpers of the peak monitor
//  Assumes : one clock, samples arrive as one-cycle valid strobes
//  Notes   : register indexes sit at byte address index*4 on the bus
package spm_pkg;

    // ==================================================================
    // widths
    localparam int SAMPLE_W  = 14;
    localparam int PEAK_W    = 13;
    localparam int PERIOD_W  = 24;
    localparam int CTRL_W    = 3;
    localparam int FRAME_W   = 25;
    localparam int SUB_W     = 5;
    localparam int SUB_N     = 5;
    localparam int PAYLOAD_W = SUB_N * (SUB_W - 1);
    localparam int IDX_W     = 12;
    localparam int ADR_W     = IDX_W + 2;

    // ==================================================================
    // register indexes (byte address = index * 4)
    localparam logic [IDX_W-1:0] IDX_CTRL   = 12'h270;
    localparam logic [IDX_W-1:0] IDX_PER_0  = 12'h271;
    localparam logic [IDX_W-1:0] IDX_PER_1  = 12'h272;
    localparam logic [IDX_W-1:0] IDX_PER_2  = 12'h273;
    localparam logic [IDX_W-1:0] IDX_HOLD_L = 12'h274;
    localparam logic [IDX_W-1:0] IDX_HOLD_H = 12'h275;
    localparam logic [IDX_W-1:0] IDX_LINK_A = 12'h279;
    localparam logic [IDX_W-1:0] IDX_LINK_B = 12'h27a;

    // ==================================================================
    // field positions and reset values
    localparam int              PEAK_EN_BIT  = 1;
    localparam logic [1:0]      LINK_A_MASK  = 2'h3;
    localparam int              LINK_B_BIT   = 1;
    localparam int              MON_CTRL_POS = CTRL_W - 1;
    localparam logic [7:0]      RST_REG8     = 8'h00;
    localparam logic [PERIOD_W-1:0] RST_PERIOD = 24'h000000;
    localparam logic [PEAK_W-1:0]   MAG_MAX    = 13'h1fff;
    localparam logic [4:0]          FRAME_CNT  = 5'h19;

    // ==================================================================
    // helpers
    // magnitude of a signed sample, clipped to 13 bits
    function automatic logic [PEAK_W-1:0] spm_mag(
        input logic [SAMPLE_W-1:0] s);
        logic [SAMPLE_W-1:0] a;
        a = s[SAMPLE_W-1] ? SAMPLE_W'(~s + 14'h0001) : s;
        return a[SAMPLE_W-1] ? MAG_MAX : a[PEAK_W-1:0];
    endfunction

    // five subframes, start bit then four payload bits, msb first
    function automatic logic [FRAME_W-1:0] spm_pack(
        input logic [PEAK_W-1:0] peak);
        logic [PAYLOAD_W-1:0] pl;
        logic [FRAME_W-1:0]   f;
        pl = {peak, 7'h00};
        f  = '0;
        for (int k = 0; k < SUB_N; k++) begin
            f[FRAME_W-1-SUB_W*k]        = 1'b1;
            f[FRAME_W-2-SUB_W*k -: 4]   = pl[PAYLOAD_W-1-4*k -: 4];
        end
        return f;
    endfunction

    // all start bits set
    function automatic logic spm_frame_ok(input logic [FRAME_W-1:0] f);
        logic ok;
        ok = 1'b1;
        for (int k = 0; k < SUB_N; k++) begin
            ok = ok & f[FRAME_W-1-SUB_W*k];
        end
        return ok;
    endfunction

    function automatic logic [PEAK_W-1:0] spm_unpack(
        input logic [FRAME_W-1:0] f);
        logic [PAYLOAD_W-1:0] pl;
        pl = '0;
        for (int k = 0; k < SUB_N; k++) begin
            pl[PAYLOAD_W-1-4*k -: 4] = f[FRAME_W-2-SUB_W*k -: 4];
        end
        return pl[PAYLOAD_W-1 -: PEAK_W];
    endfunction

endpackage

// File: logic/spm_receiver.sv
//  Purpose : link receiver end, recovers peak frames from control bits
//  Assumes : idle control bit is low between frames
//  Notes   : a frame with a missing start bit is flagged and dropped
`timescale 1ns/1ps
module spm_receiver (
    input  wire logic                          core_clk,
    input  wire logic                          rst,
    spm_link_if.rx                             link,
    output logic [spm_pkg::SAMPLE_W-1:0]       rx_sample,
    output logic                               rx_sample_valid,
    output logic [spm_pkg::PEAK_W-1:0]         peak_value,
    output logic                               peak_valid,
    output logic                               frame_error
);
    import spm_pkg::*;

    typedef struct packed {
        logic [FRAME_W-1:0]  shift;
        logic [4:0]          cnt;
        logic                busy;
        logic [SAMPLE_W-1:0] sample;
        logic                svalid;
        logic [PEAK_W-1:0]   peak;
        logic                pvalid;
        logic                ferr;
    } spm_rx_s;

    spm_rx_s            st_reg;
    spm_rx_s            st_next;
    logic               bit_in;
    logic [FRAME_W-1:0] frame;

    assign bit_in = link.link_ctrl[MON_CTRL_POS];
    assign frame  = {st_reg.shift[FRAME_W-2:0], bit_in};

    assign rx_sample       = st_reg.sample;
    assign rx_sample_valid = st_reg.svalid;
    assign peak_value      = st_reg.peak;
    assign peak_valid      = st_reg.pvalid;
    assign frame_error     = st_reg.ferr;

    // ==================================================================
    // collect 25 bits from a rising start bit on, then check and unpack
    always_comb begin
        st_next        = st_reg;
        st_next.pvalid = 1'b0;
        st_next.ferr   = 1'b0;
        st_next.svalid = link.link_valid;
        if (link.link_valid) begin
            st_next.sample = link.link_sample;
            if (!st_reg.busy) begin
                if (bit_in) begin
                    st_next.busy  = 1'b1;
                    st_next.shift = {{(FRAME_W-1){1'b0}}, 1'b1};
                    st_next.cnt   = 5'h01;
                end
            end else begin
                st_next.shift = frame;
                st_next.cnt   = st_reg.cnt + 5'h01;
                if (st_reg.cnt == FRAME_CNT - 5'h01) begin
                    st_next.busy = 1'b0;
                    if (spm_frame_ok(frame)) begin
                        st_next.peak   = spm_unpack(frame);
                        st_next.pvalid = 1'b1;
                    end else begin
                        st_next.ferr   = 1'b1;
                    end
                end
            end
        end
    end

    // state register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule

// File: tb/signal_peak_monitor_tb.sv
// Purpose : self-checking bench of monitor, link and receiver
// Assumes : samples are sent as pulses with one idle cycle between
// Notes   : a second receiver is fed by the bench with a good frame, then a broken one
`timescale 1ns/1ps
module signal_peak_monitor_tb;
    import spm_pkg::*;

    // ==================================================================
    // signals and instances
    logic                core_clk  = 1'b0;
    logic                rst       = 1'b1;
    logic                wb_cyc    = 1'b0;
    logic                wb_stb    = 1'b0;
    logic                wb_we     = 1'b0;
    logic [ADR_W-1:0]    wb_adr    = '0;
    logic [3:0]          wb_sel    = 4'h0;
    logic [31:0]         wb_dat_w  = '0;
    logic [31:0]         wb_dat_r;
    logic                wb_ack;
    logic                in_valid  = 1'b0;
    logic [SAMPLE_W-1:0] in_sample = '0;
    logic [SAMPLE_W-1:0] rs1, rs2;
    logic                rv1, rv2, pk_v, pk2_v, f_err, f2_err;
    logic [PEAK_W-1:0]   pk, pk2;
    logic [31:0]         rd;
    int                  n_fail = 0, checks = 0, n_hit = 0;
    int                  n_pk = 0, n_pk2 = 0, n_err = 0, n_err2 = 0;
    int                  n_rv = 0, n_rv2 = 0;

    spm_link_if link ();
    spm_link_if link2 ();
    spm_monitor spm_monitor_i (.core_clk(core_clk), .rst(rst),
        .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
        .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
        .wb_ack(wb_ack), .in_valid(in_valid), .in_sample(in_sample),
        .link(link));
    spm_receiver spm_receiver_i (.core_clk(core_clk), .rst(rst),
        .link(link), .rx_sample(rs1), .rx_sample_valid(rv1),
        .peak_value(pk), .peak_valid(pk_v), .frame_error(f_err));
    spm_receiver spm_receiver_i2 (.core_clk(core_clk), .rst(rst),
        .link(link2), .rx_sample(rs2), .rx_sample_valid(rv2),
        .peak_value(pk2), .peak_valid(pk2_v), .frame_error(f2_err));
    spm_link_checker spm_link_checker_i (.core_clk(core_clk), .rst(rst),
        .link_valid(link.link_valid), .link_sample(link.link_sample),
        .link_ctrl(link.link_ctrl));

    always #5 core_clk = ~core_clk;

    // tally receiver pulses and side channel bits on the link
    always @(posedge core_clk) begin
        if (pk_v === 1'b1) n_pk++;
        if (f_err === 1'b1) n_err++;
        if (pk2_v === 1'b1) n_pk2++;
        if (f2_err === 1'b1) n_err2++;
        if (rv1 === 1'b1) n_rv++;
        if (rv2 === 1'b1) n_rv2++;
        if (link.link_valid === 1'b1 && link.link_ctrl[2] === 1'b1) n_hit++;
    end

    // ==================================================================
    // shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD at %0t: %s seen %h want %h", $time, what, seen,
                     exp);
        end
    endtask

    // one classic cycle; only the watchdog ends the wait on a dead slave
    task automatic wb(input logic we, input logic [IDX_W-1:0] idx,
                      input logic [7:0] d, input logic [3:0] sel);
        @(posedge core_clk);
        wb_cyc   <= 1'b1;
        wb_stb   <= 1'b1;
        wb_we    <= we;
        wb_adr   <= {idx, 2'b00};
        wb_dat_w <= {24'h0, d};
        wb_sel   <= sel;
        do begin
            @(posedge core_clk);
        end while (wb_ack !== 1'b1);
        rd = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        // ack is a single pulse, gone one cycle later
        @(posedge core_clk);
        chk(wb_ack, 32'h0, "ack held");
    endtask

    task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d);
        wb(1'b1, idx, d, 4'h1);
    endtask

    task automatic rdchk(input logic [IDX_W-1:0] idx,
                         input logic [31:0] exp, input string what);
        wb(1'b0, idx, 8'h00, 4'h1);
        chk(rd, exp, what);
    endtask

    task automatic set_period(input logic [23:0] p);
        wr(IDX_PER_0, p[7:0]);
        wr(IDX_PER_1, p[15:8]);
        wr(IDX_PER_2, p[23:16]);
    endtask

    // sample pulse; the idle value is inverted so it cannot pass as data
    task automatic send(input logic [SAMPLE_W-1:0] s);
        @(posedge core_clk);
        in_valid  <= 1'b1;
        in_sample <= s;
        @(posedge core_clk);
        in_valid  <= 1'b0;
        in_sample <= ~s;
    endtask

    // bench framing: start bit then four payload bits, five times
    function automatic logic [24:0] mk_frame(input logic [12:0] v);
        logic [19:0] p;
        p = {v, 7'h00};
        return {1'b1, p[19:16], 1'b1, p[15:12], 1'b1, p[11:8], 1'b1,
                p[7:4], 1'b1, p[3:0]};
    endfunction

    task automatic drive_frame(input logic [24:0] f);
        for (int i = 24; i >= 0; i--) begin
            @(posedge core_clk);
            link2.link_valid <= 1'b1;
            link2.link_ctrl  <= {f[i], 2'b00};
            @(posedge core_clk);
            link2.link_valid <= 1'b0;
            link2.link_ctrl  <= {~f[i], 2'b11};
        end
        repeat (3) @(posedge core_clk);
    endtask

    // ==================================================================
    // scenarios
    task automatic t_regs();
        rdchk(IDX_CTRL, 32'h0, "ctrl reset");
        rdchk(IDX_HOLD_L, 32'h0, "hold reset");
        wr(IDX_HOLD_L, 8'h5a);
        rdchk(IDX_HOLD_L, 32'h0, "hold written");
        wb(1'b1, IDX_LINK_A, 8'h03, 4'h0);
        rdchk(IDX_LINK_A, 32'h0, "sel low write");
        wr(12'h3ff, 8'h77);
        rdchk(12'h3ff, 32'h0, "unmapped read");
        set_period(24'habcdef);
        rdchk(IDX_PER_0, 32'hef, "period low");
        rdchk(IDX_PER_2, 32'hab, "period top");
        $display("test regs done");
    endtask

    // signed samples, clipping, reseed each period, disable, period one
    task automatic t_peak();
        logic [SAMPLE_W-1:0] s [12] = '{14'h0064, 14'h3ed4, 14'h0032,
            14'h00c8, 14'h2000, 14'h0005, 14'h0001, 14'h0002, 14'h000a,
            14'h0014, 14'h3ffb, 14'h0007};
        logic [PEAK_W-1:0]   e [3] = '{13'h012c, 13'h1fff, 13'h0014};
        logic [7:0]          lo;
        set_period(24'h000004);
        wr(IDX_CTRL, 8'h02);
        for (int p = 0; p < 3; p++) begin
            for (int k = 0; k < 4; k++) send(s[4*p+k]);
            rdchk(IDX_HOLD_L, {24'h0, e[p][7:0]}, "peak low");
            lo = rd[7:0];
            rdchk(IDX_HOLD_H, {27'h0, e[p][12:8]}, "peak high");
        end
        // software view of the last peak, 20 of peak 8192 is -52 dB
        chk($rtoi(-20.0 * $log10($itor({rd[4:0], lo}) / 8192.0)), 52,
            "dbfs of last peak");
        wr(IDX_CTRL, 8'h00);
        send(14'h1000);
        rdchk(IDX_HOLD_L, 32'h14, "kept while off");
        set_period(24'h000001);
        wr(IDX_CTRL, 8'h02);
        send(14'h3fb3);
        rdchk(IDX_HOLD_L, 32'h4d, "period of one");
        $display("test peak done");
    endtask

    // side channel only with both enables; one full frame decoded
    task automatic t_link();
        logic [7:0] la [3] = '{8'h01, 8'h03, 8'h03};
        logic [7:0] lb [3] = '{8'h02, 8'h00, 8'h02};
        set_period(24'h000004);
        for (int c = 0; c < 3; c++) begin
            wr(IDX_CTRL, 8'h00);
            wr(IDX_LINK_A, la[c]);
            wr(IDX_LINK_B, lb[c]);
            wr(IDX_CTRL, 8'h02);
            n_hit = 0;
            n_pk  = 0;
            n_rv  = 0;
            for (int k = 0; k < 34; k++) send(k == 2 ? 14'h0abc : 14'h0003);
            repeat (3) @(posedge core_clk);
            // 5 start bits, 7 ones of the peak, then the next frame's start
            chk(n_hit, c == 2 ? 13 : 0, "channel gate");
            chk(n_pk, c == 2, "frame count");
            chk(n_err, 0, "frame error");
            chk(n_rv, 34, "samples through");
            chk(rs1, 14'h0003, "last sample");
        end
        chk({19'h0, pk}, 32'habc, "frame value");
        $display("test link done");
    endtask

    // receiver end fed with a good frame, then one missing a start bit
    task automatic t_bad();
        drive_frame(mk_frame(13'h1a5c));
        chk(n_pk2, 1, "good frame");
        chk({19'h0, pk2}, 32'h1a5c, "good value");
        drive_frame(mk_frame(13'h0123) & ~25'h0004000);
        chk(n_err2, 1, "bad start flagged");
        chk({19'h0, pk2}, 32'h1a5c, "bad frame dropped");
        chk(n_rv2, 50, "link samples");
        $display("test bad frame done");
    endtask

    // ==================================================================
    // run control
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        link2.link_valid  = 1'b0;
        link2.link_ctrl   = 3'h0;
        link2.link_sample = '0;
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        t_regs();
        t_peak();
        t_link();
        t_bad();
        report_and_stop();
    end

    // the whole run needs well under a thousand cycles; this is far beyond it
    initial begin
        #200000;
        n_fail++;
        $display("BAD at %0t: watchdog expired", $time);
        report_and_stop();
    end
endmodule

// File: tb/spm_link_checker.sv
// Purpose : wire checks on the link between monitor and receiver
// Assumes : one clock, active high asynchronous reset
// Notes   : frame position is counted from the first start bit seen
`timescale 1ns/1ps
module spm_link_checker (
    input  wire logic                         core_clk,
    input  wire logic                         rst,
    input  wire logic                         link_valid,
    input  wire logic [spm_pkg::SAMPLE_W-1:0] link_sample,
    input  wire logic [spm_pkg::CTRL_W-1:0]   link_ctrl
);
    import spm_pkg::*;

    // ==================================================================
    // frame position tracker
    logic [4:0] pos_reg;
    logic       zero_pos;

    // position of the next valid sample inside a frame, zero when idle
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pos_reg <= 5'h00;
        end else if (link_valid) begin
            if (pos_reg != 5'h00) begin
                pos_reg <= (pos_reg == 5'h18) ? 5'h00 : pos_reg + 5'h01;
            end else if (link_ctrl[MON_CTRL_POS]) begin
                pos_reg <= 5'h01;
            end
        end
    end

    // payload slots past the thirteen peak bits carry zeros
    assign zero_pos = pos_reg inside {5'h11, 5'h12, 5'h13, [5'h15:5'h18]};

    // ==================================================================
    // assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    reset_idle_a: assert property ($fell(rst) |-> !link_valid
        && link_ctrl == 3'h0) else $error("link busy after reset");
    low_bits_a: assert property (link_ctrl[1:0] == 2'h0)
        else $error("lower control bits used");
    start_bits_a: assert property (link_valid && pos_reg != 5'h00
        && pos_reg % 5 == 0 |-> link_ctrl[2]) else $error("start bit lost");
    zero_fill_a: assert property (link_valid && zero_pos
        |-> !link_ctrl[2]) else $error("fill bit not zero");
    ctrl_quiet_a: assert property (
        !link_valid |-> link_ctrl == 3'h0) else $error("bit without sample");
    sample_pulse_a: assert property (link_valid |=> !link_valid)
        else $error("sample held twice");
    frame_end_c: cover property (link_valid && pos_reg == 5'h18);
endmodule
